// File: common/rfcpd_defines.svh
// Constants for the RF control pin decoder
`ifndef RFCPD_DEFINES_SVH
`define RFCPD_DEFINES_SVH
`define RFCPD_SYNC_STAGES   2
`define RFCPD_PWR_W         8
`define RFCPD_PWR_MAX_RST   8'hFF
`define RFCPD_PWR_THR_RST   8'h80
`define RFCPD_TUNER_RST     4'h0
`define RFCPD_STRAP_NC      1'b1
`define RFCPD_STRAP_GND     1'b0
`define RFCPD_I2C_ADDR_RST  7'h2A
`endif

// File: common/rfcpd_pkg.sv
// Types for the RF control pin decoder
package rfcpd_pkg;
  typedef struct packed {
    logic rf_kill_n;
    logic proximity_power_limit_n;
    logic antenna_count_select;
  } rfcpd_pins_t;

  typedef struct packed {
    logic radio_on;
    logic flight_mode;
    logic power_limited;
    logic four_antennas;
  } rfcpd_state_t;

  typedef enum logic {RFCPD_TUNER_SERIAL, RFCPD_TUNER_GPO} rfcpd_tuner_mode_t;

  typedef enum logic [1:0] {RFCPD_SF_IDLE, RFCPD_SF_SHIFT, RFCPD_SF_DONE} rfcpd_sfe_state_t;
endpackage : rfcpd_pkg

// File: design/rfcpd_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/10ps
`default_nettype none
module rfcpd_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  generate
    for (genvar g = 0; g < WIDTH; g++) begin : g_lane
      logic meta_q;
      logic stab_q;
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          meta_q <= RST_VAL[g];
          stab_q <= RST_VAL[g];
        end else begin
          meta_q <= async_i[g];
          stab_q <= meta_q;
        end
      end
      assign sync_o[g] = stab_q;
    end
  endgenerate
endmodule : rfcpd_sync
`default_nettype wire

// File: design/rfcpd_top.sv
// RF control pin decoder: kill, proximity, antenna select, tuner and straps
`timescale 1ns/10ps
`default_nettype none
`include "rfcpd_defines.svh"
module rfcpd_top
  import rfcpd_pkg::*;
#(
  parameter int PWR_W   = `RFCPD_PWR_W,
  parameter int TUNER_W = 4,
  parameter int SFE_W   = 8
) (
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire rfcpd_pins_t        pins_i,
  input  wire logic               kill_ignore_i,
  input  wire logic               cmd_rf_on_i,
  input  wire logic [PWR_W-1:0]   default_max_pwr_i,
  input  wire logic [PWR_W-1:0]   thr_wdata_i,
  input  wire logic               thr_we_i,
  input  wire rfcpd_tuner_mode_t  tuner_mode_i,
  input  wire logic [TUNER_W-1:0] tuner_wdata_i,
  input  wire logic               tuner_we_i,
  input  wire logic [SFE_W-1:0]   sfe_wdata_i,
  input  wire logic               sfe_start_i,
  input  wire logic               sfe_sdata_i,
  input  wire logic               wake_req_i,
  input  wire logic               wake_clr_i,
  input  wire logic               i2c_scl_i,
  input  wire logic               i2c_sda_i,
  input  wire logic               i2c_sda_tx_i,
  output rfcpd_state_t            state_o,
  output logic [PWR_W-1:0]        max_pwr_o,
  output logic [TUNER_W-1:0]      tuner_gpo_o,
  output logic                    sfe_sclk_o,
  output logic                    sfe_sdata_o,
  output logic                    sfe_sdata_oe_n_o,
  output logic                    sfe_busy_o,
  output logic [3:0]              strap_o,
  output logic                    i2c_scl_seen_o,
  output logic                    i2c_sda_in_o,
  output logic                    i2c_sda_o,
  output logic                    i2c_sda_oe_n_o,
  output logic                    i2c_irq_n_o
);
  // Shifter needs two bits at least for its part-select
  if (PWR_W < 1 || PWR_W > 16) begin : g_bad_pwr_w
    $error("PWR_W out of range");
  end
  if (TUNER_W != 4) begin : g_bad_tuner_w
    $error("Tuner word must be four bits");
  end
  if (SFE_W < 2 || SFE_W > 64) begin : g_bad_sfe_w
    $error("SFE_W out of range");
  end

  // Idle levels of the pins are high: floating reads high
  logic [4:0] sync_w;
  rfcpd_sync #(.WIDTH(5), .RST_VAL(5'h1F)) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i ({pins_i.rf_kill_n, pins_i.proximity_power_limit_n,
               pins_i.antenna_count_select, i2c_scl_i, i2c_sda_i}),
    .sync_o  (sync_w)
  );

  logic kill_n_s;
  logic prox_n_s;
  logic ant_s;
  assign kill_n_s = sync_w[4];
  assign prox_n_s = sync_w[3];
  assign ant_s    = sync_w[2];

  // Radio enable: pin gated by config, and command always able to turn off
  logic radio_on_d;
  assign radio_on_d = cmd_rf_on_i && (kill_ignore_i || kill_n_s);

  rfcpd_state_t state_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= '{radio_on: 1'b1, flight_mode: 1'b0, power_limited: 1'b0, four_antennas: 1'b0};
    end else begin
      state_q.radio_on      <= radio_on_d;
      state_q.flight_mode   <= !radio_on_d;
      state_q.power_limited <= !prox_n_s;
      state_q.four_antennas <= !ant_s;
    end
  end
  assign state_o = state_q;

  // Threshold setting
  logic [PWR_W-1:0] thr_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      thr_q <= PWR_W'(`RFCPD_PWR_THR_RST);
    end else if (thr_we_i) begin
      thr_q <= thr_wdata_i;
    end
  end

  // Never raise power above default when the threshold is set higher
  logic [PWR_W-1:0] max_pwr_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      max_pwr_q <= PWR_W'(`RFCPD_PWR_MAX_RST);
    end else if (!prox_n_s && thr_q < default_max_pwr_i) begin
      max_pwr_q <= thr_q;
    end else begin
      max_pwr_q <= default_max_pwr_i;
    end
  end
  assign max_pwr_o = max_pwr_q;

  // Parallel tuner word, only written in GPO mode and held in serial mode
  logic [TUNER_W-1:0] tuner_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tuner_q <= `RFCPD_TUNER_RST;
    end else if (tuner_we_i && tuner_mode_i == RFCPD_TUNER_GPO) begin
      tuner_q <= tuner_wdata_i;
    end
  end
  assign tuner_gpo_o = tuner_q;

  // Serial front-end shifter: MSB first, data set as SCLK rises, steady while high
  rfcpd_sfe_state_t    sf_q;
  logic [SFE_W-1:0]    sf_shift_q;
  logic [$clog2(SFE_W+1)-1:0] sf_cnt_q;
  logic                sclk_q;
  logic                sdata_q;
  logic                busy_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sf_q       <= RFCPD_SF_IDLE;
      sf_shift_q <= '0;
      sf_cnt_q   <= '0;
      sclk_q     <= 1'b0;
      sdata_q    <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      case (sf_q)
        RFCPD_SF_IDLE: begin
          sclk_q <= 1'b0;
          if (sfe_start_i && tuner_mode_i == RFCPD_TUNER_SERIAL) begin
            sf_shift_q <= sfe_wdata_i;
            sf_cnt_q   <= '0;
            busy_q     <= 1'b1;
            sf_q       <= RFCPD_SF_SHIFT;
          end
        end
        RFCPD_SF_SHIFT: begin
          if (!sclk_q) begin
            sdata_q <= sf_shift_q[SFE_W-1];
            sclk_q  <= 1'b1;
            sf_shift_q <= {sf_shift_q[SFE_W-2:0], 1'b0};
          end else begin
            sclk_q   <= 1'b0;
            sf_cnt_q <= sf_cnt_q + 1'b1;
            if (sf_cnt_q == ($clog2(SFE_W+1))'(SFE_W - 1)) sf_q <= RFCPD_SF_DONE;
          end
        end
        RFCPD_SF_DONE: begin
          sdata_q <= 1'b0;
          busy_q  <= 1'b0;
          sf_q    <= RFCPD_SF_IDLE;
        end
        default: sf_q <= RFCPD_SF_IDLE;
      endcase
    end
  end
  assign sfe_sclk_o  = sclk_q;
  assign sfe_sdata_o = sdata_q;
  assign sfe_busy_o  = busy_q;

  // Data line released while idle so a slave can answer on sfe_sdata_i
  logic sfe_oe_n_q;
  logic sfe_rd_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sfe_oe_n_q <= 1'b1;
      sfe_rd_q   <= 1'b0;
    end else begin
      sfe_oe_n_q <= !(sf_q == RFCPD_SF_SHIFT);
      sfe_rd_q   <= sfe_sdata_i;
    end
  end
  assign sfe_sdata_oe_n_o = sfe_oe_n_q;

  // Fixed module-type strap pattern
  logic [3:0] strap_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_q <= {`RFCPD_STRAP_NC, `RFCPD_STRAP_NC, `RFCPD_STRAP_GND, `RFCPD_STRAP_NC};
    end else begin
      strap_q <= {`RFCPD_STRAP_NC, `RFCPD_STRAP_NC, `RFCPD_STRAP_GND, `RFCPD_STRAP_NC};
    end
  end
  assign strap_o = strap_q;

  // Open drain: level always low, the enable alone decides
  logic sda_drv_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_drv_q <= 1'b0;
    end else begin
      sda_drv_q <= 1'b0;
    end
  end

  // I2C target: never drives SCL; SDA only pulled low, released otherwise
  logic scl_q;
  logic sda_in_q;
  logic sda_oe_n_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q      <= 1'b1;
      sda_in_q   <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      scl_q      <= sync_w[1];
      sda_in_q   <= sync_w[0];
      sda_oe_n_q <= i2c_sda_tx_i;
    end
  end
  assign i2c_scl_seen_o = scl_q;
  assign i2c_sda_in_o   = sda_in_q;
  assign i2c_sda_o      = sda_drv_q;
  assign i2c_sda_oe_n_o = sda_oe_n_q;

  // Wake request is sticky; a request in the clear cycle wins
  logic irq_n_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_n_q <= 1'b1;
    end else if (wake_req_i) begin
      irq_n_q <= 1'b0;
    end else if (wake_clr_i) begin
      irq_n_q <= 1'b1;
    end
  end
  assign i2c_irq_n_o = irq_n_q;

  a_kill_to_flight: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!kill_n_s && !kill_ignore_i) |=> state_o.flight_mode && !state_o.radio_on)
    else $error("Kill low did not enter flight mode");
  a_kill_release: assert property (@(posedge mclk_i) disable iff (reset_i)
    (kill_n_s && cmd_rf_on_i) |=> state_o.radio_on)
    else $error("Kill high did not enable radio");
  a_kill_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
    (kill_ignore_i && cmd_rf_on_i) |=> !state_o.flight_mode)
    else $error("Ignored kill still forced flight mode");
  a_pwr_default: assert property (@(posedge mclk_i) disable iff (reset_i)
    prox_n_s |=> max_pwr_o == $past(default_max_pwr_i))
    else $error("Default power not kept");
  a_pwr_limit: assert property (@(posedge mclk_i) disable iff (reset_i)
    !prox_n_s |=> max_pwr_o <= $past(thr_q) && state_o.power_limited)
    else $error("Power not limited");
  a_thr_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    thr_we_i |=> thr_q == $past(thr_wdata_i))
    else $error("Threshold not stored");
  a_ant_count: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 state_o.four_antennas == !$past(ant_s))
    else $error("Antenna mode mismatch");
  sequence s_pin_low;
    !pins_i.antenna_count_select ##1 !pins_i.antenna_count_select ##1 !pins_i.antenna_count_select;
  endsequence
  a_ant_sync_lag: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_pin_low |=> state_o.four_antennas)
    else $error("Four-antenna mode late");
  a_tuner_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    !(tuner_we_i && tuner_mode_i == RFCPD_TUNER_GPO) |=> $stable(tuner_gpo_o))
    else $error("Tuner word changed without write");
  a_sfe_length: assert property (@(posedge mclk_i) disable iff (reset_i)
    (sf_q == RFCPD_SF_IDLE && sfe_start_i && tuner_mode_i == RFCPD_TUNER_SERIAL)
      |=> sfe_busy_o [*8])
    else $error("Serial transfer too short");
  a_strap_fixed: assert property (@(posedge mclk_i) disable iff (reset_i)
    strap_o == 4'hD)
    else $error("Strap pattern wrong");
  a_irq_wake: assert property (@(posedge mclk_i) disable iff (reset_i)
    wake_req_i |=> !i2c_irq_n_o)
    else $error("Wake interrupt not asserted");
  a_irq_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    (wake_clr_i && !wake_req_i) |=> i2c_irq_n_o)
    else $error("Wake interrupt not released");
  a_sda_target: assert property (@(posedge mclk_i) disable iff (reset_i)
    !i2c_sda_oe_n_o |-> !i2c_sda_o)
    else $error("SDA driven high");
  a_sda_follow: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 i2c_sda_oe_n_o == $past(i2c_sda_tx_i))
    else $error("SDA enable does not follow transmit request");
endmodule : rfcpd_top
`default_nettype wire

// File: test/rfcpd_far_end.sv
// Far-end model: host, body sensor, antenna strap, pulled-up SDA line and wandering serial data line
`timescale 1ns/10ps
`default_nettype none
module rfcpd_far_end
  import rfcpd_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  kill_drive_i,
  input  wire logic  near_body_i,
  input  wire logic  four_ant_i,
  input  wire logic  sfe_sdata_i,
  input  wire logic  sfe_oe_n_i,
  input  wire logic  sda_oe_n_i,
  output var rfcpd_pins_t pins_o,
  output logic       sfe_line_o,
  output logic       sda_line_o
);
  logic toggle_q = 1'b0;
  always @(posedge mclk_i) begin
    toggle_q <= ~toggle_q;
  end
  assign pins_o.rf_kill_n = ~kill_drive_i;
  assign pins_o.proximity_power_limit_n = ~near_body_i;
  assign pins_o.antenna_count_select = ~four_ant_i;
  // Released line wanders, so stale data cannot pass
  assign sfe_line_o = sfe_oe_n_i ? toggle_q : sfe_sdata_i;
  assign sda_line_o = sda_oe_n_i ? 1'b1 : 1'b0;
endmodule : rfcpd_far_end
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the RF control pin decoder
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rfcpd_pkg::*;
;
  logic mclk_i = 1'b0, reset_i = 1'b1;
  logic kill = 0, near = 0, four4 = 0, kill_ign = 0, cmd_on = 1;
  logic [7:0] def_pwr = 8'hFF, thr_wd = 8'h00, sfe_wd = 8'h00;
  logic thr_we = 0, tun_we = 0, sfe_start = 0, wake_req = 0, wake_clr = 0, scl = 1, sda_tx = 1;
  logic [3:0] tun_wd = 4'h0;
  rfcpd_tuner_mode_t tmode = RFCPD_TUNER_GPO;
  rfcpd_pins_t pins;
  rfcpd_state_t st;
  logic [7:0] max_pwr, lfsr_q = 8'h28;
  logic [3:0] tun, strap;
  logic sclk, sdo, sfe_oe_n, busy, scl_seen, sda_in, sda_o, sda_oe_n, irq_n, sfe_line, sda_line;
  int fails = 0, comparisons = 0;
  logic [7:0] m_thr = 8'h80;
  logic [3:0] m_tun = 4'h0;

  always #25 mclk_i = ~mclk_i;

  rfcpd_top i_rfcpd_top (.mclk_i(mclk_i), .reset_i(reset_i), .pins_i(pins), .kill_ignore_i(kill_ign),
    .cmd_rf_on_i(cmd_on), .default_max_pwr_i(def_pwr), .thr_wdata_i(thr_wd), .thr_we_i(thr_we),
    .tuner_mode_i(tmode), .tuner_wdata_i(tun_wd), .tuner_we_i(tun_we), .sfe_wdata_i(sfe_wd),
    .sfe_start_i(sfe_start), .sfe_sdata_i(sfe_line), .wake_req_i(wake_req), .wake_clr_i(wake_clr),
    .i2c_scl_i(scl), .i2c_sda_i(sda_line), .i2c_sda_tx_i(sda_tx), .state_o(st), .max_pwr_o(max_pwr),
    .tuner_gpo_o(tun), .sfe_sclk_o(sclk), .sfe_sdata_o(sdo), .sfe_sdata_oe_n_o(sfe_oe_n),
    .sfe_busy_o(busy), .strap_o(strap), .i2c_scl_seen_o(scl_seen), .i2c_sda_in_o(sda_in),
    .i2c_sda_o(sda_o), .i2c_sda_oe_n_o(sda_oe_n), .i2c_irq_n_o(irq_n));

  rfcpd_far_end i_rfcpd_far_end (.mclk_i(mclk_i), .kill_drive_i(kill), .near_body_i(near),
    .four_ant_i(four4), .sfe_sdata_i(sdo), .sfe_oe_n_i(sfe_oe_n), .sda_oe_n_i(sda_oe_n),
    .pins_o(pins), .sfe_line_o(sfe_line), .sda_line_o(sda_line));

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic rnd(output logic [7:0] v);
    lfsr_q = lfsr_next(lfsr_q);
    v = lfsr_q;
  endtask : rnd

  task automatic check_state();
    logic on;
    logic [7:0] cap;
    on = cmd_on && (kill_ign || !kill);
    cap = (m_thr < def_pwr) ? m_thr : def_pwr;
    chk("state", {4'h0, st}, {4'h0, on, !on, near, four4});
    chk("power", max_pwr, near ? cap : def_pwr);
  endtask : check_state

  task automatic wake(input logic rq, input logic cl, input logic exp);
    wake_req = rq;
    wake_clr = cl;
    @(negedge mclk_i);
    wake_req = 0;
    wake_clr = 0;
    chk("irq", {7'h0, irq_n}, {7'h0, exp});
    @(negedge mclk_i);
  endtask : wake

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    #200_000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [7:0] r;
    logic [1:0] prev;
    logic q[$];
    logic last;
    repeat (6) @(negedge mclk_i);
    reset_i = 1'b0;
    chk("strap", {4'h0, strap}, 8'h0D);
    chk("tuner", {4'h0, tun}, 8'h00);
    check_state();
    $display("Reset test done");
    rnd(r);
    thr_wd = r;
    thr_we = 1;
    @(negedge mclk_i);
    rnd(r);
    thr_wd = r;
    m_thr = r;
    @(negedge mclk_i);
    thr_we = 0;
    near = 1;
    repeat (3) @(negedge mclk_i);
    check_state();
    prev = {st.power_limited, st.four_antennas};
    for (int i = 0; i < 32; i++) begin
      {kill, kill_ign, cmd_on, near, four4} = i[4:0];
      rnd(r);
      def_pwr = r;
      repeat (2) @(negedge mclk_i);
      chk("sync", {6'h0, st.power_limited, st.four_antennas}, {6'h0, prev});
      @(negedge mclk_i);
      check_state();
      prev = {st.power_limited, st.four_antennas};
    end
    $display("Pin test done");
    for (int i = 0; i < 4; i++) begin
      tmode = i[1] ? RFCPD_TUNER_SERIAL : RFCPD_TUNER_GPO;
      rnd(r);
      tun_wd = r[3:0];
      tun_we = 1;
      @(negedge mclk_i);
      tun_we = 0;
      if (!i[1]) m_tun = r[3:0];
      chk("gpo", {4'h0, tun}, {4'h0, m_tun});
      @(negedge mclk_i);
    end
    rnd(r);
    sfe_wd = r;
    sfe_start = 1;
    @(negedge mclk_i);
    sfe_start = 0;
    last = 0;
    for (int c = 0; c < 40 && (q.size() < 8 || busy); c++) begin
      @(negedge mclk_i);
      if (sclk && !last) q.push_back(sfe_line);
      last = sclk;
    end
    chk("bits", q.size(), 8);
    for (int j = 0; j < 8 && j < q.size(); j++) chk("sbit", {7'h0, q[j]}, {7'h0, r[7-j]});
    chk("busy", {7'h0, busy}, 8'h00);
    chk("sfe_oe", {7'h0, sfe_oe_n}, 8'h01);
    $display("Tuner test done");
    wake(1, 0, 0);
    wake(0, 1, 1);
    wake(1, 1, 0);
    wake(0, 1, 1);
    sda_tx = 0;
    scl = 0;
    repeat (5) @(negedge mclk_i);
    chk("sda", {sda_o, sda_oe_n, sda_in, scl_seen}, 8'h00);
    sda_tx = 1;
    scl = 1;
    repeat (5) @(negedge mclk_i);
    chk("sda", {sda_o, sda_oe_n, sda_in, scl_seen}, 8'h07);
    $display("I2C test done");
    wake(1, 0, 0);
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    m_thr = 8'h80;
    m_tun = 4'h0;
    chk("irq", {7'h0, irq_n}, 8'h01);
    chk("tuner", {4'h0, tun}, {4'h0, m_tun});
    repeat (3) @(negedge mclk_i);
    check_state();
    $display("Mid-run reset test done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
